//--- dv/asf_codec_model.sv
`timescale 1ns/10ps
module asf_codec_model (
  input  wire logic                      rst_n,    // bench reset
  input  wire asf_pkg::asf_link_out_type linkOut,  // device link pins
  input  wire logic                      msb,      // 1 msb-justified
  input  wire logic [15:0]               word,     // sample sent each half
  output      logic                      dataIn,   // data to device
  output      logic [15:0]               leftWord  // first left word heard
);
  logic [4:0]  idx;
  logic [4:0]  pos;
  logic [15:0] sh;
  logic        ts;
  logic        rs;
  logic        got;

  initial dataIn = 1'b0;
  // bits outside the word toggle so no stale value passes as data
  always @(negedge linkOut.bitClk or negedge rst_n) begin
    if (!rst_n) begin
      idx = 5'h1F;
      ts = 1'b0;
    end else begin
      // sync moves in the same step as the clock; let it settle first
      #1;
      idx = (linkOut.frameSync != ts) ? 5'h00 : idx + 5'h01;
      ts = linkOut.frameSync;
      // i2s sends the last bit of a word after the sync change
      pos = (!msb && idx == 5'h00) ? 5'h0F : idx - {4'h0, ~msb};
      dataIn <= (pos < 5'h10) ? word[4'hF - pos[3:0]] : ~dataIn;
    end
  end
  // word ends at the sync change; i2s still owes its last bit there
  always @(posedge linkOut.bitClk or negedge rst_n) begin
    if (!rst_n) begin
      rs = 1'b0;
      got = 1'b0;
      leftWord <= 16'h0000;
    end else begin
      if (linkOut.frameSync != rs && rs == msb && !got) begin
        leftWord <= msb ? sh : {sh[14:0], linkOut.dataOut};
        got = 1'b1;
      end
      rs = linkOut.frameSync;
      sh = {sh[14:0], linkOut.dataOut};
    end
  end
endmodule

//--- dv/asf_serial_ctrl_properties.sv
`timescale 1ns/10ps
module asf_serial_ctrl_checker (
  input wire logic                      clk,     // system clock
  input wire logic                      rst_n,   // sync reset
  input wire asf_pkg::asf_axi_req_type  axiReq,  // bus requests
  input wire asf_pkg::asf_axi_rsp_type  axiRsp,  // bus answers
  input wire asf_pkg::asf_link_out_type linkOut  // link pins
);
  import asf_pkg::*;
  logic [ADDR_W-1:0] rdAddr_q;
  logic              isStat;
  logic              isFmt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdAddr_q <= '0;
    end else if (axiReq.arvalid && axiRsp.arready) begin
      rdAddr_q <= axiReq.araddr;
    end
  end
  // slave ignores the two low address bits
  assign isStat = axiRsp.rvalid && rdAddr_q[7:2] == OFS_STATUS[7:2];
  assign isFmt  = axiRsp.rvalid && rdAddr_q[7:2] == OFS_FMT[7:2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bHold; axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid; endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped");
  property p_rHold;
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read answer dropped");
  property p_errZero; axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR |-> axiRsp.rdata == '0;
  endproperty
  a_errZero: assert property (p_errZero) else $error("error read not zero");
  property p_fmtZero; isFmt |-> axiRsp.rdata[31:13] == '0 && axiRsp.rdata[11:5] == '0;
  endproperty
  a_fmtZero: assert property (p_fmtZero) else $error("format spare bits set");
  property p_statZero;
    isStat |-> {axiRsp.rdata[31:30], axiRsp.rdata[23:14],
                axiRsp.rdata[7], axiRsp.rdata[2:0]} == '0;
  endproperty
  a_statZero: assert property (p_statZero) else $error("status spare bits set");
  property p_levels;
    isStat |-> axiRsp.rdata[29:24] <= LVL_FULL && axiRsp.rdata[13:8] <= LVL_FULL;
  endproperty
  a_levels: assert property (p_levels) else $error("level above full");
  property p_mclk; linkOut.masterClk |=> !linkOut.masterClk; endproperty
  a_mclk: assert property (p_mclk) else $error("master clock not halved");
  property p_linkHold;
    $rose(linkOut.bitClk) |-> $stable(linkOut.frameSync) && $stable(linkOut.dataOut);
  endproperty
  a_linkHold: assert property (p_linkHold) else $error("link moved on rising");
endmodule

bind asf_serial_ctrl asf_serial_ctrl_checker i_chk (
  .clk(clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp), .linkOut(linkOut));

//--- dv/tb_asf_serial_ctrl.sv
`timescale 1ns/10ps
module tb_asf_serial_ctrl;
  import asf_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b1;
  asf_axi_req_type  axiReq = '0;
  asf_axi_rsp_type  axiRsp;
  logic             serialDataIn;
  asf_link_out_type linkOut;
  logic             rxDmaReq;
  logic             txDmaReq;
  logic             irq;
  logic             msb = 1'b0;
  logic [15:0]      word = 16'h0000;
  logic [15:0]      leftWord;
  logic [1:0]       resp;
  int               seed = 18;
  int               n_mismatch = 0;
  int               n_checks = 0;

  always #25 clk = ~clk;

  asf_serial_ctrl i_dut (.clk(clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .serialDataIn(serialDataIn), .linkOut(linkOut), .rxDmaReq(rxDmaReq),
    .txDmaReq(txDmaReq), .irq(irq));
  asf_codec_model i_codec (.rst_n(rst_n), .linkOut(linkOut), .msb(msb), .word(word),
    .dataIn(serialDataIn), .leftWord(leftWord));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      t++;
    end while (axiRsp.bvalid !== 1'b1 && t < 50);
    axiReq.bready <= 1'b0;
    if (t >= 50) n_mismatch++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int t;
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      t++;
    end while (axiRsp.rvalid !== 1'b1 && t < 50);
    axiReq.rready <= 1'b0;
    d = axiRsp.rdata;
    resp = axiRsp.rresp;
    if (t >= 50) n_mismatch++;
  endtask

  task automatic cnt(input logic [31:0] e);
    logic [31:0] h;
    h = '0;
    repeat (8) begin
      @(posedge clk);
      h = h + linkOut.masterClk;
    end
    chk(h, e);
  endtask

  task automatic run(input logic f);
    logic [31:0] st;
    logic [31:0] th;
    logic [31:0] lvl;
    logic [31:0] cfg;
    logic [31:0] first;
    logic        b;
    int          k;
    st = $random(seed);
    rst_n <= 1'b0;
    msb <= f;
    word <= st[15:0];
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_STATUS, st);
    chk(st, 32'h00000018);
    rd(8'h18, st);
    chk({st[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(OFS_FMT, 32'h00001000 | f);
    th = $unsigned($random(seed)) % 32;
    cfg = 32'h03002039 | (th << CFG_TXTH);
    wr(OFS_CFG, cfg);
    wr(OFS_FMT, 32'hFFFFFFFF);
    rd(OFS_FMT, st);
    chk(st, 32'h00001011);
    cnt(32'h4);
    wr(OFS_FMT, 32'h00001000 | f);
    cnt(32'h0);
    wr(OFS_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    for (k = 1; k <= 33; k++) begin
      st = $random(seed);
      if (k == 1) first = {16'h0, st[15:0]};
      wr(OFS_DATA, st);
      rd(OFS_STATUS, st);
      lvl = (k > 32) ? 32 : k;
      chk({26'h0, st[13:8]}, lvl);
      chk({31'h0, st[ST_TFS]}, {31'h0, lvl <= th});
      chk({31'h0, txDmaReq}, {31'h0, lvl <= th});
    end
    wr(OFS_IRQ_STAT, 32'hF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_FMT, {31'h0, f});
    k = 0;
    do begin
      rd(OFS_STATUS, st);
      k++;
    end while (!(st[ST_ROR] === 1'b1 && st[ST_TUR] === 1'b1) && k < 4000);
    chk({16'h0, leftWord}, first);
    wr(OFS_FMT, 32'h00001000 | f);
    repeat (2) @(posedge clk);
    b = linkOut.bitClk;
    repeat (16) begin
      @(posedge clk);
      chk({31'h0, linkOut.bitClk}, {31'h0, b});
    end
    wr(OFS_STATUS, 32'hFFFFFFFF);
    rd(OFS_STATUS, st);
    chk(st, 32'h20000078);
    chk({31'h0, rxDmaReq}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_STATUS, 32'h0);
    // first sample is the partial word caught at start-up
    rd(OFS_DATA, st);
    rd(OFS_DATA, st);
    chk(st & 32'hFFFF, {16'h0, word});
    rd(OFS_STATUS, st);
    chk(st, 32'h1E000008);
    chk({31'h0, rxDmaReq}, 32'h0);
    wr(OFS_CFG, cfg | 32'h2);
    wr(OFS_FMT, 32'h00000010);
    cnt(32'h0);
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    run(1'b0);
    run(1'b1);
    complete_run;
  end

  // both passes need about 0.5 ms
  initial begin
    #3000000;
    n_mismatch++;
    complete_run;
  end
endmodule

//--- rtl/asf_pkg.sv
package asf_pkg;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int SMP_W      = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int PTR_W      = 5;
  localparam int LVL_W      = 6;
  localparam int DIV_W      = 8;
  localparam int IRQ_W      = 4;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_FMT      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

  // serial_format_control fields
  localparam int FMT_STOP  = 12;
  localparam int FMT_SYSEN = 4;
  localparam int FMT_MSB   = 0;
  // fifo_status fields
  localparam int ST_RFL = 24;
  localparam int ST_TFL = 8;
  localparam int ST_ROR = 6;
  localparam int ST_TUR = 5;
  localparam int ST_RFS = 4;
  localparam int ST_TFS = 3;
  // frame_configuration fields
  localparam int CFG_EN     = 0;
  localparam int CFG_ACLINK = 1;
  localparam int CFG_RXIE   = 2;
  localparam int CFG_TXIE   = 3;
  localparam int CFG_RXDE   = 4;
  localparam int CFG_TXDE   = 5;
  localparam int CFG_RXTH   = 8;
  localparam int CFG_TXTH   = 16;
  localparam int CFG_DIV    = 24;
  localparam logic [DATA_W-1:0] CFG_MASK = 32'hFF3F3F3F;
  // interrupt status / mask bits
  localparam int IRQ_ROR = 0;
  localparam int IRQ_TUR = 1;
  localparam int IRQ_RFS = 2;
  localparam int IRQ_TFS = 3;

  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;
  localparam logic [4:0]       BITCNT_RST  = 5'h1F;
  localparam logic [3:0]       WORD_FIRST  = 4'h0;
  localparam logic [3:0]       WORD_LAST   = 4'hF;
  localparam logic [LVL_W-1:0] LVL_FULL    = 6'h20;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } asf_axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } asf_axi_rsp_type;

  typedef struct packed {
    logic bitClk;
    logic frameSync;
    logic dataOut;
    logic masterClk;
  } asf_link_out_type;

  function automatic logic [DATA_W-1:0] mergeStrb(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] nw,
                                                  input logic [3:0]        strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // bit position inside a channel word; i2s lags frame sync by one bit
  function automatic logic [4:0] wordPos(input logic [4:0] cnt, input logic msb);
    return cnt - {4'h0, ~msb};
  endfunction
endpackage

//--- rtl/asf_sample_mem.sv
`timescale 1ns/10ps
module asf_sample_mem (
  input  wire logic                       clk,    // system clock
  input  wire logic                       rst_n,  // synchronous reset
  input  wire logic                       wrEn,   // write strobe
  input  wire logic [asf_pkg::PTR_W-1:0]  wrAddr, // write address
  input  wire logic [asf_pkg::SMP_W-1:0]  wrData, // write sample
  input  wire logic [asf_pkg::PTR_W-1:0]  rdAddr, // read address
  output      logic [asf_pkg::SMP_W-1:0]  rdData  // registered read sample
);
  import asf_pkg::*;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][SMP_W-1:0] mem;
    logic [SMP_W-1:0]                 rd;
  } asf_mem_state_type;

  asf_mem_state_type s_q;
  asf_mem_state_type s_d;

  always_comb begin
    s_d    = s_q;
    s_d.rd = s_q.mem[rdAddr];
    if (wrEn) begin
      s_d.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rd;
endmodule

//--- rtl/asf_serial_ctrl.sv
`timescale 1ns/10ps
// Function
// - stop control halts bit clock when set
// - ac-link format ignores this control register
// - enable bit drives master clock out
// - format select: 0 i2s, 1 msb-justified
// - reserved bits ignore writes, read zero
// - receive level read-only, 0 to 32
// - transmit level read-only, 0 to 32
// - sticky overrun on write to full receive
// - sticky underrun on read of empty transmit
// - write 0 clears flags, 1 keeps
// - receive request while level at/above threshold
// - transmit request while level at/below threshold
// - requests raise interrupt and/or dma by enables
module asf_serial_ctrl (
  input  wire logic                      clk,          // 20 MHz system clock
  input  wire logic                      rst_n,        // synchronous reset
  input  wire asf_pkg::asf_axi_req_type  axiReq,       // axi4-lite master to slave
  output      asf_pkg::asf_axi_rsp_type  axiRsp,       // axi4-lite slave to master
  input  wire logic                      serialDataIn, // serial data from codec
  output      asf_pkg::asf_link_out_type linkOut,      // serial link pins
  output      logic                      rxDmaReq,     // receive dma request
  output      logic                      txDmaReq,     // transmit dma request
  output      logic                      irq           // level interrupt
);
  import asf_pkg::*;

  typedef struct packed {
    logic              awHave;
    logic [ADDR_W-1:0] awAddr;
    logic              wHave;
    logic [DATA_W-1:0] wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0]        rResp;
    logic              stop;
    logic              sysEn;
    logic              msbFmt;
    logic [DATA_W-1:0] cfg;
    logic              receive_overrun_flag;
    logic              transmit_underrun_flag;
    logic [IRQ_W-1:0]  irqStat;
    logic [IRQ_W-1:0]  irqMask;
    logic [LVL_W-1:0]  txWr;
    logic [LVL_W-1:0]  txRd;
    logic [LVL_W-1:0]  rxWr;
    logic [LVL_W-1:0]  rxRd;
    logic              txPushed;
    logic              rxPushed;
    logic [DIV_W-1:0]  divCnt;
    logic              bck;
    logic [4:0]        bitCnt;
    logic [SMP_W-1:0]  txSh;
    logic [SMP_W-1:0]  rxSh;
    logic              sdOut;
    logic              lr;
    logic              sdMeta;
    logic              sdSync;
    logic              mclk;
  } asf_core_state_type;

  asf_core_state_type s_q;
  asf_core_state_type s_d;

  logic [SMP_W-1:0] txRdData;
  logic [SMP_W-1:0] rxRdData;
  logic [LVL_W-1:0] txLvl;
  logic [LVL_W-1:0] rxLvl;
  logic             receive_service_request;
  logic             transmit_service_request;
  logic             acLink;
  logic             engRun;
  logic             txPush;
  logic             rxPush;
  logic [4:0]       curPos;

  assign txLvl  = s_q.txWr - s_q.txRd;
  assign rxLvl  = s_q.rxWr - s_q.rxRd;
  assign receive_service_request    = rxLvl >= s_q.cfg[CFG_RXTH +: LVL_W];
  assign transmit_service_request    = txLvl <= s_q.cfg[CFG_TXTH +: LVL_W];
  assign acLink = s_q.cfg[CFG_ACLINK];
  // stop only counts in the serial formats; ac-link leaves the engine idle
  assign engRun = s_q.cfg[CFG_EN] & ~acLink & ~s_q.stop;

  // a sample written last cycle is not yet on the registered read port
  assign txPush = s_q.awHave & s_q.wHave & ({s_q.awAddr[ADDR_W-1:2], 2'b00} == OFS_DATA)
                  & (txLvl != LVL_FULL) & s_q.wStrb[0] & s_q.wStrb[1];
  assign curPos = wordPos(s_q.bitCnt, s_q.msbFmt);
  assign rxPush = engRun && (s_q.divCnt == s_q.cfg[CFG_DIV +: DIV_W]) && !s_q.bck
                  && (curPos[3:0] == WORD_LAST)
                  && (rxLvl != LVL_FULL);

  asf_sample_mem txMem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (txPush),
    .wrAddr (s_q.txWr[PTR_W-1:0]),
    .wrData (s_q.wData[SMP_W-1:0]),
    .rdAddr (s_q.txRd[PTR_W-1:0]),
    .rdData (txRdData)
  );

  asf_sample_mem rxMem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (rxPush),
    .wrAddr (s_q.rxWr[PTR_W-1:0]),
    .wrData ({s_q.rxSh[SMP_W-2:0], s_q.sdSync}),
    .rdAddr (s_q.rxRd[PTR_W-1:0]),
    .rdData (rxRdData)
  );

  always_comb begin
    logic [DATA_W-1:0] mw;
    logic [DATA_W-1:0] rw;
    logic [ADDR_W-1:0] ra;
    logic [ADDR_W-1:0] wa;
    logic [4:0]        cnt;
    logic [4:0]        pos;
    logic [LVL_W-1:0]  txAvail;
    logic [LVL_W-1:0]  rxAvail;
    logic              halfTick;
    logic [IRQ_W-1:0]  irqSet;
    mw       = '0;
    rw       = '0;
    ra       = {axiReq.araddr[ADDR_W-1:2], 2'b00};
    wa       = {s_q.awAddr[ADDR_W-1:2], 2'b00};
    cnt      = s_q.bitCnt;
    pos      = wordPos(s_q.bitCnt, s_q.msbFmt);
    txAvail  = txLvl - {5'h00, s_q.txPushed};
    rxAvail  = rxLvl - {5'h00, s_q.rxPushed};
    halfTick = engRun && (s_q.divCnt == s_q.cfg[CFG_DIV +: DIV_W]);
    irqSet   = '0;
    s_d      = s_q;

    // pin input: two flops before anything looks at it
    s_d.sdMeta   = serialDataIn;
    s_d.sdSync   = s_q.sdMeta;
    s_d.txPushed = txPush;
    s_d.rxPushed = rxPush;

    // write channel: address and data taken in either order
    if (axiReq.awvalid && axiRsp.awready) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      s_d.wHave = 1'b1;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end
    if (s_q.bValid && axiReq.bready) begin
      s_d.bValid = 1'b0;
    end
    if (s_q.awHave && s_q.wHave) begin
      s_d.awHave = 1'b0;
      s_d.wHave  = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp  = RESP_OKAY;
      case (wa)
        OFS_FMT: begin
          mw         = mergeStrb({19'h0, s_q.stop, 7'h00, s_q.sysEn, 3'h0, s_q.msbFmt},
                                 s_q.wData, s_q.wStrb);
          s_d.stop   = mw[FMT_STOP];
          s_d.sysEn  = mw[FMT_SYSEN];
          s_d.msbFmt = mw[FMT_MSB];
        end
        OFS_STATUS: begin
          mw = mergeStrb({DATA_W{1'b1}}, s_q.wData, s_q.wStrb);
          if (!mw[ST_ROR]) begin
            s_d.receive_overrun_flag = 1'b0;
          end
          if (!mw[ST_TUR]) begin
            s_d.transmit_underrun_flag = 1'b0;
          end
        end
        OFS_CFG: begin
          s_d.cfg = mergeStrb(s_q.cfg, s_q.wData, s_q.wStrb) & CFG_MASK;
        end
        OFS_DATA: begin
          if (txPush) begin
            s_d.txWr = s_q.txWr + 6'h01;
          end
        end
        OFS_IRQ_STAT: begin
          mw          = mergeStrb('0, s_q.wData, s_q.wStrb);
          s_d.irqStat = s_q.irqStat & ~mw[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          mw          = mergeStrb({28'h0000000, s_q.irqMask}, s_q.wData, s_q.wStrb);
          s_d.irqMask = mw[IRQ_W-1:0];
        end
        default: begin
          s_d.bResp = RESP_SLVERR;
        end
      endcase
    end

    // read channel: one read in flight, data taken at the address edge
    if (s_q.rValid && axiReq.rready) begin
      s_d.rValid = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      s_d.rValid = 1'b1;
      s_d.rResp  = RESP_OKAY;
      case (ra)
        OFS_FMT: begin
          rw[FMT_STOP]  = s_q.stop;
          rw[FMT_SYSEN] = s_q.sysEn;
          rw[FMT_MSB]   = s_q.msbFmt;
        end
        OFS_STATUS: begin
          rw[ST_RFL +: LVL_W] = rxLvl;
          rw[ST_TFL +: LVL_W] = txLvl;
          rw[ST_ROR]          = s_q.receive_overrun_flag;
          rw[ST_TUR]          = s_q.transmit_underrun_flag;
          rw[ST_RFS]          = receive_service_request;
          rw[ST_TFS]          = transmit_service_request;
        end
        OFS_CFG: begin
          rw = s_q.cfg;
        end
        OFS_DATA: begin
          // empty fifo reads zero and pops nothing
          if (rxAvail != '0) begin
            rw[SMP_W-1:0] = rxRdData;
            s_d.rxRd      = s_q.rxRd + 6'h01;
          end
        end
        OFS_IRQ_STAT: begin
          rw[IRQ_W-1:0] = s_q.irqStat;
        end
        OFS_IRQ_MASK: begin
          rw[IRQ_W-1:0] = s_q.irqMask;
        end
        default: begin
          s_d.rResp = RESP_SLVERR;
        end
      endcase
      s_d.rData = rw;
    end

    // serial engine; bit clock half period is divider+1 cycles
    if (engRun) begin
      s_d.divCnt = halfTick ? '0 : s_q.divCnt + 8'h01;
    end
    if (halfTick) begin
      s_d.bck = ~s_q.bck;
      if (s_q.bck) begin
        cnt        = s_q.bitCnt + 5'h01;
        pos        = wordPos(cnt, s_q.msbFmt);
        s_d.bitCnt = cnt;
        s_d.lr     = cnt[4] ^ s_q.msbFmt;
        if (pos[3:0] == WORD_FIRST) begin
          if (txAvail != '0) begin
            s_d.txSh = txRdData;
            s_d.txRd = s_q.txRd + 6'h01;
          end else begin
            s_d.txSh = '0;
            s_d.transmit_underrun_flag  = 1'b1;
            irqSet[IRQ_TUR] = 1'b1;
          end
        end else begin
          s_d.txSh = {s_q.txSh[SMP_W-2:0], 1'b0};
        end
        s_d.sdOut = s_d.txSh[SMP_W-1];
      end else begin
        s_d.rxSh = {s_q.rxSh[SMP_W-2:0], s_q.sdSync};
        if (pos[3:0] == WORD_LAST) begin
          if (rxPush) begin
            s_d.rxWr = s_q.rxWr + 6'h01;
          end else begin
            s_d.receive_overrun_flag = 1'b1;
            irqSet[IRQ_ROR] = 1'b1;
          end
        end
      end
    end

    // master clock runs at half the system clock while enabled, outside ac-link
    s_d.mclk = (s_q.sysEn & ~acLink) ? ~s_q.mclk : 1'b0;

    // sticky interrupt bits; a set in the clearing cycle still lands
    irqSet[IRQ_RFS] = receive_service_request & s_q.cfg[CFG_RXIE];
    irqSet[IRQ_TFS] = transmit_service_request & s_q.cfg[CFG_TXIE];
    s_d.irqStat     = s_d.irqStat | irqSet;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.bitCnt <= BITCNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign axiRsp.awready   = ~s_q.awHave & ~s_q.bValid;
  assign axiRsp.wready    = ~s_q.wHave & ~s_q.bValid;
  assign axiRsp.bvalid    = s_q.bValid;
  assign axiRsp.bresp     = s_q.bResp;
  assign axiRsp.arready   = ~s_q.rValid;
  assign axiRsp.rvalid    = s_q.rValid;
  assign axiRsp.rdata     = s_q.rData;
  assign axiRsp.rresp     = s_q.rResp;
  assign linkOut.bitClk    = s_q.bck;
  assign linkOut.frameSync = s_q.lr;
  assign linkOut.dataOut   = s_q.sdOut;
  assign linkOut.masterClk = s_q.mclk;
  assign rxDmaReq = receive_service_request & s_q.cfg[CFG_RXDE];
  assign txDmaReq = transmit_service_request & s_q.cfg[CFG_TXDE];
  assign irq      = |(s_q.irqStat & s_q.irqMask);
endmodule
